/* hdl/rsld_consts.svh */
`ifndef RSLD_CONSTS_SVH
`define RSLD_CONSTS_SVH

// ********************************************************************
// Clock and timing
// ********************************************************************
`define RSLD_CLK_HZ          10000000
`define RSLD_RED_HOLD_S      30
`define RSLD_BLINK_HALF_MS   500

// ********************************************************************
// Register map and fields
// ********************************************************************
`define RSLD_ADDR_W          12
`define RSLD_OFS_CTRL        12'h000
`define RSLD_OFS_THRESH      12'h004
`define RSLD_OFS_LAMPS       12'h008
`define RSLD_OFS_FLAGS       12'h00C
`define RSLD_CTRL_REF_LSB    0
`define RSLD_CTRL_TIME_LSB   2
`define RSLD_CTRL_PRI_BIT    4
`define RSLD_THRESH_LSB      0
`define RSLD_QFIG_W          8
`define RSLD_THRESH_RST      8'h40

`endif

/* hdl/rsld_pkg.sv */
`include "rsld_consts.svh"

package rsld_pkg;

	typedef enum logic [2:0] {col_off, col_green, col_amber, col_yellow, col_orange, col_red} rsld_colour_t;

	typedef struct packed {
		rsld_colour_t colour;
		logic         bright;
	} rsld_lamp_t;

	typedef enum logic [1:0] {ref_internal, ref_satellite, ref_genlock, ref_unused} rsld_ref_src_t;
	typedef enum logic [1:0] {time_program, time_satellite, time_vitc, time_ltc} rsld_time_src_t;

	typedef struct packed {
		rsld_ref_src_t  ref_src;
		rsld_time_src_t time_src;
		logic           primary_two;
	} rsld_ctrl_t;

	typedef struct packed {
		logic                     sat_fitted;
		logic                     osc_warming;
		logic                     gps_locked;
		logic [`RSLD_QFIG_W-1:0]  gps_quality_figure;
		logic                     genlock_locked;
		logic                     genlock_near_loss;
		logic                     time_missing;
		logic                     ltc_same_rate;
		logic                     ltc_out_of_tol;
		logic                     ltc_bad_timing;
	} rsld_ref_flags_t;

	typedef struct packed {
		logic installed;
		logic powered;
		logic volt_margin;
		logic volt_fault;
		logic hours_over;
		logic fan_fail;
	} rsld_supply_t;

	typedef struct packed {
		logic                    psel;
		logic                    penable;
		logic                    pwrite;
		logic [`RSLD_ADDR_W-1:0] paddr;
		logic [31:0]             pwdata;
	} rsld_apb_req_t;

endpackage

/* hdl/rsld_supply_lamp.sv */
`timescale 1ns/1ns
`default_nettype none

module rsld_supply_lamp #(
	parameter int unsigned HOLD_CYCLES = 300000000
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire rsld_pkg::rsld_supply_t flags,
	input  wire logic               is_active,
	output var  rsld_pkg::rsld_lamp_t   front_lamp,
	output var  rsld_pkg::rsld_lamp_t   rear_lamp
);
	import rsld_pkg::*;

	localparam int CW = $clog2(HOLD_CYCLES + 1);

	if (HOLD_CYCLES < 1)
	begin : g_bad_hold
		$error("HOLD_CYCLES must be at least one");
	end

	logic          fault_now;
	logic          warn_now;
	logic [CW-1:0] hold_q;
	rsld_lamp_t    lamp_d;

	// ********************************************************************
	// Fault and warning conditions
	// ********************************************************************
	assign fault_now = flags.installed & (~flags.powered | flags.volt_fault | (flags.fan_fail & ~is_active)); // see RQ19
	assign warn_now  = flags.volt_margin | flags.hours_over | (flags.fan_fail & is_active); // see RQ14 see RQ15 see RQ18

	// Red stays up for the hold time after the fault goes away
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_q <= '0;
		else if (!flags.installed)
			hold_q <= '0;
		else if (fault_now)
			hold_q <= CW'(HOLD_CYCLES); // see RQ20
		else if (hold_q != '0)
			hold_q <= hold_q - 1'b1;
	end

	// ********************************************************************
	// Lamp decode, most severe first
	// ********************************************************************
	always_comb
	begin
		lamp_d = '{colour: col_off, bright: 1'b0};
		if (!flags.installed)
			lamp_d = '{colour: col_off, bright: 1'b0}; // see RQ11
		else if (fault_now || hold_q != '0)
			lamp_d = '{colour: col_red, bright: 1'b1}; // see RQ23
		else if (warn_now)
			lamp_d = '{colour: col_orange, bright: is_active}; // see RQ21
		else
			lamp_d = '{colour: col_green, bright: is_active}; // see RQ12 see RQ13 see RQ17
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			front_lamp <= '{colour: col_off, bright: 1'b0};
			rear_lamp  <= '{colour: col_off, bright: 1'b0};
		end
		else
		begin
			front_lamp <= lamp_d;
			rear_lamp  <= lamp_d; // see RQ16
		end
	end

	// ********************************************************************
	// Checks
	// ********************************************************************
	chk_absent_off: assert property (@(posedge clk) disable iff (!rst_n) // see RQ11
		!flags.installed |=> front_lamp.colour == col_off)
		else $error("absent supply lamp not off");
	chk_red_on_fault: assert property (@(posedge clk) disable iff (!rst_n) // see RQ19
		fault_now |=> front_lamp == '{colour: col_red, bright: 1'b1})
		else $error("faulted supply not red");
	chk_red_hold: assert property (@(posedge clk) disable iff (!rst_n) // see RQ20
		(HOLD_CYCLES > 8 && fault_now ##1 (!fault_now && flags.installed)[*8])
		|-> front_lamp.colour == col_red)
		else $error("red dropped before hold time");
	chk_warn_orange: assert property (@(posedge clk) disable iff (!rst_n) // see RQ14
		(flags.installed && !fault_now && hold_q == '0 && warn_now)
		|=> front_lamp.colour == col_orange && front_lamp.bright == $past(is_active))
		else $error("warning supply not orange at the right brightness");
	chk_clean_green: assert property (@(posedge clk) disable iff (!rst_n) // see RQ13
		(flags.installed && !fault_now && hold_q == '0 && !warn_now)
		|=> front_lamp.colour == col_green && front_lamp.bright == $past(is_active))
		else $error("healthy supply not green at the right brightness");
	chk_rear_mirror: assert property (@(posedge clk) disable iff (!rst_n) // see RQ16
		rear_lamp == front_lamp)
		else $error("rear lamp differs from front lamp");
	cov_red_released: cover property (@(posedge clk) disable iff (!rst_n)
		front_lamp.colour == col_red ##1 front_lamp.colour == col_green);

endmodule

`default_nettype wire

/* hdl/rsld_top.sv */
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "rsld_consts.svh"

// Functional notes
// RQ1: Internal reference: locked lamp off; oscillator lamp green, blinking while warming.
// RQ2: Satellite or genlock locked and good: locked lamp green, oscillator lamp off.
// RQ3: Selected external reference unlocked: locked lamp red, oscillator lamp green.
// RQ4: Poor satellite quality or genlock near loss: locked lamp amber, oscillator off.
// RQ5: No satellite receiver fitted and satellite selected: both reference lamps off.
// RQ6: Satellite quality figure is compared against a software-set warning threshold.
// RQ7: Programmed time: time lamp off; healthy external time: time lamp green.
// RQ8: Timecode at another rate, or same rate within tolerance, shows green.
// RQ9: Timecode at same rate but outside tolerance shows yellow.
// RQ10: Missing, discontinuous or badly timed timecode shows red.
// RQ11: Supply position without a module has its lamp off.
// RQ12: Healthy backup of two powered supplies shows dim green.
// RQ13: Healthy active supply shows bright green.
// RQ14: Backup supply with marginal voltage shows dim orange.
// RQ15: Backup supply over its heat-weighted hours shows dim orange.
// RQ16: Each rear supply lamp copies its front supply lamp.
// RQ17: Each supply lamp decodes only its own module flags.
// RQ18: Active supply with marginal voltage, hours over or fan failure: bright orange.
// RQ19: Supply output voltage out of range or supply failed: lamp red.
// RQ20: Red supply state holds about thirty seconds after the fault clears.
// RQ21: Orange states clear at once when the marginal condition goes away.
// RQ22: Warm-up blink period is a parameter in clock cycles.
// RQ23: Supply lamp shows most severe state: red, orange, green, off.

module rsld_top #(
	parameter int unsigned RED_HOLD_CYCLES = `RSLD_RED_HOLD_S * `RSLD_CLK_HZ,
	parameter int unsigned BLINK_CYCLES    = `RSLD_BLINK_HALF_MS * (`RSLD_CLK_HZ / 1000)
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire rsld_pkg::rsld_apb_req_t apb,
	output var  logic [31:0]             prdata,
	output var  logic                    pready,
	output var  logic                    pslverr,
	input  wire rsld_pkg::rsld_ref_flags_t ref_flags,
	input  wire rsld_pkg::rsld_supply_t  supply_one_flags,
	input  wire rsld_pkg::rsld_supply_t  supply_two_flags,
	output var  rsld_pkg::rsld_lamp_t    locked_ref_lamp,
	output var  rsld_pkg::rsld_lamp_t    local_osc_lamp,
	output var  rsld_pkg::rsld_lamp_t    time_lamp,
	output var  rsld_pkg::rsld_lamp_t    supply_one_lamp,
	output var  rsld_pkg::rsld_lamp_t    supply_two_lamp,
	output var  rsld_pkg::rsld_lamp_t    supply_one_rear_lamp,
	output var  rsld_pkg::rsld_lamp_t    supply_two_rear_lamp
);
	import rsld_pkg::*;

	localparam int         BW       = $clog2(BLINK_CYCLES + 1);
	localparam rsld_lamp_t LAMP_OFF = '{colour: col_off, bright: 1'b0};

	if (BLINK_CYCLES < 1)
	begin : g_bad_blink
		$error("BLINK_CYCLES must be at least one");
	end

	function automatic rsld_lamp_t lit(input rsld_colour_t c);
		return '{colour: c, bright: 1'b1};
	endfunction

	rsld_ref_flags_t         ref_m_q;
	rsld_ref_flags_t         ref_s_q;
	rsld_supply_t            s1_m_q;
	rsld_supply_t            s1_s_q;
	rsld_supply_t            s2_m_q;
	rsld_supply_t            s2_s_q;
	rsld_ctrl_t              ctrl_q;
	logic [`RSLD_QFIG_W-1:0] thresh_q;
	logic [BW-1:0]           blink_cnt_q;
	logic                    blink_q;
	logic                    setup;
	logic                    acc_wr;
	logic                    addr_hit;
	logic [31:0]             rd_d;
	logic                    quality_low;
	logic                    up1;
	logic                    up2;
	logic                    two_up;
	logic                    active_two;
	rsld_lamp_t              ref_d;
	rsld_lamp_t              osc_d;
	rsld_lamp_t              time_d;

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_m_q <= '0;
			ref_s_q <= '0;
			s1_m_q  <= '0;
			s1_s_q  <= '0;
			s2_m_q  <= '0;
			s2_s_q  <= '0;
		end
		else
		begin
			ref_m_q <= ref_flags;
			ref_s_q <= ref_m_q;
			s1_m_q  <= supply_one_flags;
			s1_s_q  <= s1_m_q;
			s2_m_q  <= supply_two_flags;
			s2_s_q  <= s2_m_q;
		end
	end

	// ********************************************************************
	// APB slave, one access cycle, registered answer
	// ********************************************************************
	assign setup  = apb.psel & ~apb.penable;
	assign acc_wr = apb.psel & apb.penable & pready & apb.pwrite & ~pslverr;

	always_comb
	begin
		addr_hit = 1'b0;
		rd_d     = 32'h0000_0000;
		if (apb.paddr == `RSLD_OFS_CTRL)
		begin
			addr_hit = 1'b1;
			rd_d[`RSLD_CTRL_REF_LSB +: 2]  = ctrl_q.ref_src;
			rd_d[`RSLD_CTRL_TIME_LSB +: 2] = ctrl_q.time_src;
			rd_d[`RSLD_CTRL_PRI_BIT]       = ctrl_q.primary_two;
		end
		else if (apb.paddr == `RSLD_OFS_THRESH)
		begin
			addr_hit = 1'b1;
			rd_d[`RSLD_THRESH_LSB +: `RSLD_QFIG_W] = thresh_q;
		end
		else if (apb.paddr == `RSLD_OFS_LAMPS)
		begin
			addr_hit = ~apb.pwrite;
			rd_d     = 32'({locked_ref_lamp, local_osc_lamp, time_lamp, supply_one_lamp, supply_two_lamp});
		end
		else if (apb.paddr == `RSLD_OFS_FLAGS)
		begin
			addr_hit = ~apb.pwrite;
			rd_d     = 32'({ref_s_q, s1_s_q, s2_s_q});
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~addr_hit;
			prdata  <= (setup & ~apb.pwrite) ? rd_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q   <= '{ref_src: ref_internal, time_src: time_program, primary_two: 1'b0};
			thresh_q <= `RSLD_THRESH_RST;
		end
		else if (acc_wr && apb.paddr == `RSLD_OFS_CTRL)
		begin
			ctrl_q.ref_src     <= rsld_ref_src_t'(apb.pwdata[`RSLD_CTRL_REF_LSB +: 2]);
			ctrl_q.time_src    <= rsld_time_src_t'(apb.pwdata[`RSLD_CTRL_TIME_LSB +: 2]);
			ctrl_q.primary_two <= apb.pwdata[`RSLD_CTRL_PRI_BIT];
		end
		else if (acc_wr && apb.paddr == `RSLD_OFS_THRESH)
			thresh_q <= apb.pwdata[`RSLD_THRESH_LSB +: `RSLD_QFIG_W]; // see RQ6
	end

	// ********************************************************************
	// Warm-up blink divider
	// ********************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end
		else if (blink_cnt_q == BW'(BLINK_CYCLES - 1))
		begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q; // see RQ22
		end
		else
			blink_cnt_q <= blink_cnt_q + 1'b1;
	end

	// ********************************************************************
	// Reference lamps
	// ********************************************************************
	assign quality_low = ref_s_q.gps_quality_figure < thresh_q; // see RQ6

	always_comb
	begin
		ref_d = LAMP_OFF;
		osc_d = LAMP_OFF;
		case (ctrl_q.ref_src)
			ref_internal:
				osc_d = (ref_s_q.osc_warming && !blink_q) ? LAMP_OFF : lit(col_green); // see RQ1
			ref_satellite:
				if (!ref_s_q.sat_fitted)
					ref_d = LAMP_OFF; // see RQ5
				else if (!ref_s_q.gps_locked)
				begin
					ref_d = lit(col_red); // see RQ3
					osc_d = lit(col_green);
				end
				else if (quality_low)
					ref_d = lit(col_amber); // see RQ4
				else
					ref_d = lit(col_green); // see RQ2
			ref_genlock:
				if (!ref_s_q.genlock_locked)
				begin
					ref_d = lit(col_red); // see RQ3
					osc_d = lit(col_green);
				end
				else if (ref_s_q.genlock_near_loss)
					ref_d = lit(col_amber); // see RQ4
				else
					ref_d = lit(col_green); // see RQ2
			default:
				ref_d = LAMP_OFF;
		endcase
	end

	// ********************************************************************
	// Time lamp
	// ********************************************************************
	always_comb
	begin
		time_d = LAMP_OFF;
		if (ctrl_q.time_src == time_program)
			time_d = LAMP_OFF; // see RQ7
		else if (ref_s_q.time_missing)
			time_d = lit(col_red); // see RQ10
		else if (ctrl_q.time_src == time_ltc && ref_s_q.ltc_bad_timing)
			time_d = lit(col_red); // see RQ10
		else if (ctrl_q.time_src == time_ltc && ref_s_q.ltc_same_rate && ref_s_q.ltc_out_of_tol)
			time_d = lit(col_yellow); // see RQ9
		else
			time_d = lit(col_green); // see RQ7 see RQ8
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			locked_ref_lamp <= LAMP_OFF;
			local_osc_lamp  <= LAMP_OFF;
			time_lamp       <= LAMP_OFF;
		end
		else
		begin
			locked_ref_lamp <= ref_d;
			local_osc_lamp  <= osc_d;
			time_lamp       <= time_d;
		end
	end

	// ********************************************************************
	// Supply lamps
	// ********************************************************************
	assign up1        = s1_s_q.installed & s1_s_q.powered & ~s1_s_q.volt_fault;
	assign up2        = s2_s_q.installed & s2_s_q.powered & ~s2_s_q.volt_fault;
	assign two_up     = up1 & up2;
	assign active_two = two_up ? ctrl_q.primary_two : (up2 | (~up1 & ctrl_q.primary_two));

	rsld_supply_lamp #(
		.HOLD_CYCLES (RED_HOLD_CYCLES)
	) u_supply_one (
		.clk        (clk),
		.rst_n      (rst_n),
		.flags      (s1_s_q),
		.is_active  (~active_two),
		.front_lamp (supply_one_lamp),
		.rear_lamp  (supply_one_rear_lamp)
	);

	rsld_supply_lamp #(
		.HOLD_CYCLES (RED_HOLD_CYCLES)
	) u_supply_two (
		.clk        (clk),
		.rst_n      (rst_n),
		.flags      (s2_s_q),
		.is_active  (active_two),
		.front_lamp (supply_two_lamp),
		.rear_lamp  (supply_two_rear_lamp)
	);

	// ********************************************************************
	// Checks
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_int_ref_lamps: assert property ( // see RQ1
		(rst_n && ctrl_q.ref_src == ref_internal)
		|=> locked_ref_lamp == LAMP_OFF && local_osc_lamp.colour == ((!$past(ref_s_q.osc_warming) || $past(blink_q))
		? col_green : col_off))
		else $error("internal reference lamps wrong");
	chk_ref_good_green: assert property ( // see RQ2
		(ctrl_q.ref_src == ref_genlock && ref_s_q.genlock_locked && !ref_s_q.genlock_near_loss)
		|=> locked_ref_lamp.colour == col_green && local_osc_lamp == LAMP_OFF)
		else $error("locked genlock lamps wrong");
	chk_unlock_red: assert property ( // see RQ3
		((ctrl_q.ref_src == ref_satellite && ref_s_q.sat_fitted && !ref_s_q.gps_locked)
		|| (ctrl_q.ref_src == ref_genlock && !ref_s_q.genlock_locked))
		|=> locked_ref_lamp.colour == col_red && local_osc_lamp.colour == col_green)
		else $error("unlocked reference lamps wrong");
	chk_quality_amber: assert property ( // see RQ4
		(ctrl_q.ref_src == ref_satellite && ref_s_q.sat_fitted && ref_s_q.gps_locked)
		|=> locked_ref_lamp.colour == ($past(ref_s_q.gps_quality_figure) < $past(thresh_q) ? col_amber : col_green)
		&& local_osc_lamp == LAMP_OFF)
		else $error("satellite quality lamp wrong");
	chk_no_option_off: assert property ( // see RQ5
		(ctrl_q.ref_src == ref_satellite && !ref_s_q.sat_fitted)
		|=> locked_ref_lamp == LAMP_OFF && local_osc_lamp == LAMP_OFF)
		else $error("unfitted satellite lamps not off");
	chk_time_yellow: assert property ( // see RQ9
		(ctrl_q.time_src == time_ltc && !ref_s_q.time_missing && !ref_s_q.ltc_bad_timing
		&& ref_s_q.ltc_same_rate && ref_s_q.ltc_out_of_tol)
		|=> time_lamp.colour == col_yellow)
		else $error("timecode tolerance lamp not yellow");
	chk_time_red: assert property ( // see RQ10
		(ctrl_q.time_src != time_program && ref_s_q.time_missing) |=> time_lamp.colour == col_red)
		else $error("missing time lamp not red");
	chk_time_off: assert property ( // see RQ7
		(ctrl_q.time_src == time_program) |=> time_lamp == LAMP_OFF)
		else $error("programmed time lamp not off");
	chk_apb_answer: assert property (
		setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");
	chk_backup_dim: assert property ( // see RQ12
		(two_up && !ctrl_q.primary_two && !s2_s_q.volt_margin && !s2_s_q.hours_over && !s2_s_q.fan_fail)
		|=> supply_two_lamp == '{colour: col_green, bright: 1'b0} || supply_two_lamp.colour == col_red)
		else $error("healthy backup not dim green");

	cov_warm_blink: cover property (local_osc_lamp.colour == col_green ##1 local_osc_lamp.colour == col_off);
	cov_gps_amber: cover property (locked_ref_lamp.colour == col_amber);
	cov_time_yellow: cover property (time_lamp.colour == col_yellow);
	cov_bad_addr: cover property (pready && pslverr);

endmodule

`default_nettype wire

/* testbench/rsld_monitor_model.sv */
`timescale 1ns/1ns
`default_nettype none

module rsld_monitor_model (
	input  wire logic                      clk,
	output var  rsld_pkg::rsld_ref_flags_t ref_flags,
	output var  rsld_pkg::rsld_supply_t    sup_one,
	output var  rsld_pkg::rsld_supply_t    sup_two
);
	import rsld_pkg::*;

	// ****************************************
	// Status monitor outputs, held as levels
	// ****************************************
	initial
	begin
		ref_flags = '0;
		sup_one = '0;
		sup_two = '0;
	end

	task automatic put_ref(input rsld_ref_flags_t v);
		@(posedge clk);
		ref_flags <= v;
	endtask

	task automatic put_sup(input rsld_supply_t a, input rsld_supply_t b);
		@(posedge clk);
		sup_one <= a;
		sup_two <= b;
	endtask
endmodule

`default_nettype wire

/* testbench/rsld_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module rsld_top_tb_top;
	import rsld_pkg::*;

	localparam rsld_supply_t S_NO = 6'h00;
	localparam rsld_supply_t S_OK = 6'h30;
	localparam rsld_supply_t S_MG = 6'h38;
	localparam rsld_supply_t S_HR = 6'h32;
	localparam rsld_supply_t S_FN = 6'h31;
	localparam rsld_supply_t S_FT = 6'h3C;

	logic            clk;
	logic            rst_n;
	rsld_apb_req_t   apb;
	logic [31:0]     prdata;
	logic            pready;
	logic            pslverr;
	rsld_ref_flags_t rfl;
	rsld_supply_t    s1;
	rsld_supply_t    s2;
	rsld_lamp_t      lk, lo, lt, l1, l2, r1, r2;
	logic [31:0]     rdat;
	logic            rerr;
	int              err_count = 0;
	int              n_compared = 0;
	int              cyc = 0;

	rsld_monitor_model mon (.clk(clk), .ref_flags(rfl), .sup_one(s1), .sup_two(s2));

	rsld_top #(.RED_HOLD_CYCLES(20), .BLINK_CYCLES(4)) DUT (
		.clk(clk), .rst_n(rst_n), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_flags(rfl), .supply_one_flags(s1), .supply_two_flags(s2), .locked_ref_lamp(lk),
		.local_osc_lamp(lo), .time_lamp(lt), .supply_one_lamp(l1), .supply_two_lamp(l2),
		.supply_one_rear_lamp(r1), .supply_two_rear_lamp(r2));

	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic rsld_lamp_t lp(rsld_colour_t c, logic b);
		lp = '{colour: c, bright: b};
	endfunction

	task automatic xfer(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		apb.penable <= 1'b1;
		// Only pready high ends this wait; the bench timeout bounds it
		do
		begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		// Lamps are looked at mid-cycle, once settled
		@(negedge clk);
	endtask

	task automatic ref_step(rsld_ref_flags_t v, rsld_lamp_t el, rsld_lamp_t eo);
		mon.put_ref(v);
		settle();
		chk("locked_ref_lamp", {28'h0, lk}, {28'h0, el});
		chk("local_osc_lamp", {28'h0, lo}, {28'h0, eo});
	endtask

	task automatic tm_step(logic [1:0] src, rsld_ref_flags_t v, rsld_lamp_t e);
		xfer(1'b1, 12'h000, {28'h0, src, 2'h0});
		mon.put_ref(v);
		settle();
		chk("time_lamp", {28'h0, lt}, {28'h0, e});
	endtask

	task automatic sup_step(rsld_supply_t a, rsld_supply_t b, rsld_lamp_t e1, rsld_lamp_t e2, int w);
		mon.put_sup(a, b);
		repeat (w) @(posedge clk);
		@(negedge clk);
		chk("supply_one_lamp", {28'h0, l1}, {28'h0, e1});
		chk("supply_two_lamp", {28'h0, l2}, {28'h0, e2});
		chk("supply_one_rear", {28'h0, r1}, {28'h0, e1});
		chk("supply_two_rear", {28'h0, r2}, {28'h0, e2});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset();
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("osc", {28'h0, lo}, {28'h0, lp(col_green, 1'b1)});
		chk("time", {28'h0, lt}, {28'h0, lp(col_off, 1'b0)});
		chk("sup1", {28'h0, l1}, {28'h0, lp(col_off, 1'b0)});
		xfer(1'b0, 12'h004, 32'h0);
		chk("thresh reset", rdat, 32'h00000040);
		xfer(1'b0, 12'h010, 32'h0);
		chk("unmapped err", {31'h0, rerr}, 32'h1);
		xfer(1'b1, 12'h008, 32'hFFFFFFFF);
		chk("ro write err", {31'h0, rerr}, 32'h1);
		$display("done: reset");
	endtask

	task automatic test_ref();
		rsld_ref_flags_t v;
		int g, o;
		g = 0;
		o = 0;
		v = '0;
		v.osc_warming = 1'b1;
		mon.put_ref(v);
		settle();
		repeat (16)
		begin
			@(negedge clk);
			if (lo === lp(col_green, 1'b1)) g++;
			else if (lo === lp(col_off, 1'b0)) o++;
		end
		chk("blink", {30'h0, g > 0, o > 0}, 32'h3);
		xfer(1'b1, 12'h000, 32'h1);
		v = '0;
		v.sat_fitted = 1'b1;
		v.gps_locked = 1'b1;
		v.gps_quality_figure = 8'h40;
		ref_step(v, lp(col_green, 1'b1), lp(col_off, 1'b0));
		v.gps_quality_figure = 8'h3F;
		ref_step(v, lp(col_amber, 1'b1), lp(col_off, 1'b0));
		xfer(1'b1, 12'h004, 32'h30);
		ref_step(v, lp(col_green, 1'b1), lp(col_off, 1'b0));
		v.gps_locked = 1'b0;
		ref_step(v, lp(col_red, 1'b1), lp(col_green, 1'b1));
		v.sat_fitted = 1'b0;
		ref_step(v, lp(col_off, 1'b0), lp(col_off, 1'b0));
		xfer(1'b1, 12'h000, 32'h2);
		v.genlock_locked = 1'b1;
		ref_step(v, lp(col_green, 1'b1), lp(col_off, 1'b0));
		v.genlock_near_loss = 1'b1;
		ref_step(v, lp(col_amber, 1'b1), lp(col_off, 1'b0));
		v.genlock_locked = 1'b0;
		ref_step(v, lp(col_red, 1'b1), lp(col_green, 1'b1));
		xfer(1'b1, 12'h000, 32'h3);
		ref_step(v, lp(col_off, 1'b0), lp(col_off, 1'b0));
		$display("done: reference lamps");
	endtask

	task automatic test_time();
		rsld_ref_flags_t v;
		v = '0;
		v.time_missing = 1'b1;
		tm_step(2'h0, v, lp(col_off, 1'b0));
		for (int s = 1; s < 4; s++)
			tm_step(s[1:0], '0, lp(col_green, 1'b1));
		tm_step(2'h2, v, lp(col_red, 1'b1));
		v = '0;
		v.ltc_bad_timing = 1'b1;
		tm_step(2'h2, v, lp(col_green, 1'b1));
		tm_step(2'h3, v, lp(col_red, 1'b1));
		v = '0;
		v.ltc_out_of_tol = 1'b1;
		tm_step(2'h3, v, lp(col_green, 1'b1));
		v.ltc_same_rate = 1'b1;
		tm_step(2'h3, v, lp(col_yellow, 1'b1));
		v.ltc_out_of_tol = 1'b0;
		tm_step(2'h3, v, lp(col_green, 1'b1));
		$display("done: time lamp");
	endtask

	task automatic test_supply();
		xfer(1'b1, 12'h000, 32'h0);
		sup_step(S_OK, S_NO, lp(col_green, 1'b1), lp(col_off, 1'b0), 4);
		sup_step(S_OK, S_OK, lp(col_green, 1'b1), lp(col_green, 1'b0), 4);
		sup_step(S_OK, S_MG, lp(col_green, 1'b1), lp(col_orange, 1'b0), 4);
		sup_step(S_OK, S_OK, lp(col_green, 1'b1), lp(col_green, 1'b0), 4);
		sup_step(S_OK, S_HR, lp(col_green, 1'b1), lp(col_orange, 1'b0), 4);
		sup_step(S_FN, S_OK, lp(col_orange, 1'b1), lp(col_green, 1'b0), 4);
		sup_step(S_MG, S_OK, lp(col_orange, 1'b1), lp(col_green, 1'b0), 4);
		xfer(1'b1, 12'h000, 32'h10);
		sup_step(S_OK, S_OK, lp(col_green, 1'b0), lp(col_green, 1'b1), 4);
		xfer(1'b1, 12'h000, 32'h0);
		sup_step(S_OK, S_FT, lp(col_green, 1'b1), lp(col_red, 1'b1), 4);
		sup_step(S_OK, S_OK, lp(col_green, 1'b1), lp(col_red, 1'b1), 13);
		sup_step(S_OK, S_OK, lp(col_green, 1'b1), lp(col_green, 1'b0), 25);
		sup_step(S_OK, 6'h20, lp(col_green, 1'b1), lp(col_red, 1'b1), 4);
		sup_step(S_OK, S_FN, lp(col_green, 1'b1), lp(col_red, 1'b1), 4);
		$display("done: supply lamps");
	endtask

	initial
	begin
		rst_n = 1'b0;
		apb = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_ref();
		test_time();
		test_supply();
		complete_run();
	end
endmodule

`default_nettype wire
